// File: pkg/sft_pkg.sv
// sft_pkg: register map, field positions and reset values of the
// fill-character transmitter.
// assumes a 32-bit AHB-Lite slave decoding byte offsets in haddr[7:0].
package sft_pkg;
    ////////////////////////////////////////////////////////////////////
    localparam logic [7:0] SFT_OFS_CTRL = 8'h00;
    localparam logic [7:0] SFT_OFS_DATA = 8'h04;
    localparam logic [7:0] SFT_OFS_FILL = 8'h08;
    localparam logic [7:0] SFT_OFS_STATE = 8'h0C;
    localparam logic [7:0] SFT_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] SFT_OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] SFT_OFS_IRQ_EN = 8'h18;
    ////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int SFT_CTRL_LEN_LO = 0;
    localparam int SFT_CTRL_LEN_HI = 1;
    localparam int SFT_CTRL_PAR_EVEN = 2;
    localparam int SFT_CTRL_NO_PAR = 3;
    localparam int SFT_CTRL_W = 4;
    // state and interrupt fields share one layout
    localparam int SFT_EV_BUF_TAKEN = 0;
    localparam int SFT_EV_FILL_SENT = 1;
    localparam int SFT_EV_W = 2;
    ////////////////////////////////////////////////////////////////////
    // reset: 8 data bits, no parity
    localparam logic [3:0] SFT_CTRL_RST = 4'hB;
    localparam logic [7:0] SFT_FILL_RST = 8'h00;
    localparam logic [7:0] SFT_DATA_RST = 8'h00;
    localparam logic [1:0] SFT_IRQ_EN_RST = 2'h0;
    localparam logic [3:0] SFT_MIN_BITS = 4'h5;
    localparam logic [1:0] SFT_HTRANS_NONSEQ = 2'h2;
endpackage : sft_pkg

// File: hdl/sft_shift_engine.sv
// sft_shift_engine: serialises one character per frame, choosing the
// data buffer or the fill character at each frame start.
// assumes bit_tick is a one-cycle pulse per link clock rising edge.
`timescale 1ns/1ps
module sft_shift_engine
    import sft_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic bit_tick,
    input wire logic [1:0] word_len_sel,
    input wire logic par_en,
    input wire logic par_even,
    input wire logic buf_full,
    input wire logic [7:0] buf_data,
    input wire logic [7:0] fill_data,
    output logic take_buf,
    output logic take_fill,
    output logic [3:0] frame_bits,
    output logic serial_out
);
    ////////////////////////////////////////////////////////////////////
    logic [3:0] cnt_r;
    logic [8:0] sr_r;
    logic [3:0] len;
    logic [7:0] src;
    logic [7:0] masked;
    logic par_bit;
    logic [8:0] frame;

    // word length 5..8 from the two select bits
    assign len = SFT_MIN_BITS + {2'b00, word_len_sel};
    assign frame_bits = len + {3'b000, par_en};
    // the choice is made only at a frame boundary
    assign take_buf = bit_tick && (cnt_r == 4'h0) && buf_full;
    assign take_fill = bit_tick && (cnt_r == 4'h0) && !buf_full;
    assign src = buf_full ? buf_data : fill_data;
    assign masked = src & (8'hFF >> (2'd3 - word_len_sel));
    // even parity makes the total count of ones even
    assign par_bit = par_even ? ^masked : ~^masked;
    // the parity bit sits just above the last data bit
    assign frame = {1'b0, masked}
        | (par_en ? ({8'h00, par_bit} << len) : 9'h000);

    ////////////////////////////////////////////////////////////////////
    // one bit per link clock rising edge, lsb first
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_r <= 4'h0;
            sr_r <= 9'h000;
            serial_out <= 1'b1;
        end
        else if (bit_tick)
        begin
            if (cnt_r == 4'h0)
            begin
                serial_out <= frame[0];
                sr_r <= frame >> 1;
                cnt_r <= frame_bits - 4'h1;
            end
            else
            begin
                serial_out <= sr_r[0];
                sr_r <= sr_r >> 1;
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule : sft_shift_engine

// File: hdl/sft_transmitter.sv
// sft_transmitter: AHB-Lite register front end, link clock sampling,
// buffer and flag logic, interrupts of the fill-character transmitter.
// assumes one AHB-Lite master, zero-wait slave, link clock far slower
// than hclk (at least 4 hclk cycles high and low).
`timescale 1ns/1ps
module sft_transmitter
    import sft_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic tx_shift_clock,
    output logic tx_serial_out,
    output logic tx_buffer_empty,
    output logic fill_char_sent,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////
    logic wr_ph_r;
    logic [7:0] addr_r;
    logic addr_ok;
    logic [31:0] rdata_nxt;
    logic [3:0] ctrl_r;
    logic [7:0] data_r;
    logic [7:0] fill_r;
    logic buf_full_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;
    logic link_s1_r;
    logic link_s2_r;
    logic link_s3_r;
    logic bit_tick;
    logic take_buf;
    logic take_fill;
    logic [3:0] frame_bits;
    logic data_wr;
    logic fill_wr;
    logic ctrl_wr;
    logic clr_wr;
    logic en_wr;

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always OKAY
    assign addr_ok = hsel && hready && htrans[1];
    assign data_wr = wr_ph_r && (addr_r == SFT_OFS_DATA);
    assign fill_wr = wr_ph_r && (addr_r == SFT_OFS_FILL);
    assign ctrl_wr = wr_ph_r && (addr_r == SFT_OFS_CTRL);
    assign clr_wr = wr_ph_r && (addr_r == SFT_OFS_IRQ_CLR);
    assign en_wr = wr_ph_r && (addr_r == SFT_OFS_IRQ_EN);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ph_r <= 1'b0;
            addr_r <= 8'h00;
        end
        else
        begin
            wr_ph_r <= addr_ok && hwrite;
            addr_r <= {haddr[7:2], 2'b00};
        end
    end

    // read data is built in the address phase so it stands in the data
    // phase; unmapped and write-only offsets read as zero
    always_comb
    begin
        rdata_nxt = 32'h0;
        case ({haddr[7:2], 2'b00})
            SFT_OFS_CTRL: rdata_nxt = {28'h0, ctrl_r};
            SFT_OFS_DATA: rdata_nxt = {24'h0, data_r};
            SFT_OFS_FILL: rdata_nxt = {24'h0, fill_r};
            SFT_OFS_STATE: rdata_nxt = {30'h0, fill_char_sent,
                tx_buffer_empty};
            SFT_OFS_IRQ_STAT: rdata_nxt = {30'h0, irq_stat_r};
            SFT_OFS_IRQ_EN: rdata_nxt = {30'h0, irq_en_r};
            default: rdata_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hrdata <= (addr_ok && !hwrite) ? rdata_nxt : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software-held settings and characters
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r <= SFT_CTRL_RST;
            fill_r <= SFT_FILL_RST;
            data_r <= SFT_DATA_RST;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_r <= hwdata[SFT_CTRL_W-1:0];
            if (fill_wr)
                fill_r <= hwdata[7:0];
            if (data_wr)
                data_r <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link clock is asynchronous: two flops, then edge detect on s2/s3
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link_s1_r <= 1'b0;
            link_s2_r <= 1'b0;
            link_s3_r <= 1'b0;
        end
        else
        begin
            link_s1_r <= tx_shift_clock;
            link_s2_r <= link_s1_r;
            link_s3_r <= link_s2_r;
        end
    end

    assign bit_tick = link_s2_r && !link_s3_r;

    sft_shift_engine u_engine (
        .hclk(hclk),
        .hresetn(hresetn),
        .bit_tick(bit_tick),
        .word_len_sel({ctrl_r[SFT_CTRL_LEN_HI], ctrl_r[SFT_CTRL_LEN_LO]}),
        .par_en(!ctrl_r[SFT_CTRL_NO_PAR]),
        .par_even(ctrl_r[SFT_CTRL_PAR_EVEN]),
        .buf_full(buf_full_r),
        .buf_data(data_r),
        .fill_data(fill_r),
        .take_buf(take_buf),
        .take_fill(take_fill),
        .frame_bits(frame_bits),
        .serial_out(tx_serial_out)
    );

    ////////////////////////////////////////////////////////////////////
    // buffer state: a load in the same cycle as a take wins, since the
    // shifter already copied the old character
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            buf_full_r <= 1'b0;
            tx_buffer_empty <= 1'b1;
        end
        else if (data_wr)
        begin
            buf_full_r <= 1'b1;
            tx_buffer_empty <= 1'b0;
        end
        else if (take_buf)
        begin
            buf_full_r <= 1'b0;
            tx_buffer_empty <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fill_char_sent <= 1'b0;
        else if (take_fill)
            fill_char_sent <= 1'b1;
        else if (take_buf)
            fill_char_sent <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts: set beats a clear written in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_en_r <= SFT_IRQ_EN_RST;
        else if (en_wr)
            irq_en_r <= hwdata[SFT_EV_W-1:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_stat_r <= 2'h0;
        else
        begin
            irq_stat_r[SFT_EV_BUF_TAKEN] <= take_buf
                || (irq_stat_r[SFT_EV_BUF_TAKEN]
                && !(clr_wr && hwdata[SFT_EV_BUF_TAKEN]));
            irq_stat_r[SFT_EV_FILL_SENT] <= take_fill
                || (irq_stat_r[SFT_EV_FILL_SENT]
                && !(clr_wr && hwdata[SFT_EV_FILL_SENT]));
        end
    end

    // registered output, so it trails the status bit by one cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & irq_en_r);
    end

    ////////////////////////////////////////////////////////////////////
    // helper: ticks since the last frame start, and that frame's length
    logic [4:0] ticks_r;
    logic [3:0] last_len_r;
    logic started_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ticks_r <= 5'h00;
            last_len_r <= 4'h0;
            started_r <= 1'b0;
        end
        else if (take_buf || take_fill)
        begin
            ticks_r <= 5'h01;
            last_len_r <= frame_bits;
            started_r <= 1'b1;
        end
        else if (bit_tick && ticks_r != 5'h1F)
            ticks_r <= ticks_r + 5'h01;
    end

    AST_EMPTY_TRACKS_BUF: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(tx_buffer_empty) |-> $past(data_wr || take_buf))
        else $error("buffer empty flag moved without load or take");

    AST_DATA_ONLY_IF_LOADED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take_buf |-> (buf_full_r && !tx_buffer_empty))
        else $error("buffer character sent without a load");

    AST_FILL_IF_NOT_LOADED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (bit_tick && ticks_r == {1'b0, last_len_r} && started_r
        && !buf_full_r) |-> take_fill)
        else $error("fill character not inserted at frame start");

    AST_FILL_FLAG_SET: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take_fill |=> fill_char_sent)
        else $error("fill sent flag not set");

    AST_FILL_FLAG_CLR: assert property (
        @(posedge hclk) disable iff (!hresetn)
        take_buf |=> !fill_char_sent)
        else $error("fill sent flag not cleared");

    AST_FRAME_LENGTH: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((take_buf || take_fill) && started_r)
        |-> (ticks_r == {1'b0, last_len_r}))
        else $error("character frame has wrong bit count");

    AST_LINE_MOVES_ON_TICK: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(tx_serial_out) |-> $past(bit_tick))
        else $error("serial line changed without a link clock edge");

    AST_LOAD_ON_TICK: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (take_buf || take_fill)
        |=> (tx_serial_out == $past(take_buf ? data_r[0] : fill_r[0])))
        else $error("first line bit not from the chosen character");

    AST_EMPTY_FALLS_ON_LOAD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        data_wr |=> !tx_buffer_empty ##1 1)
        else $error("buffer empty did not drop on load");

    AST_EMPTY_RISES_ON_TAKE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (take_buf && !data_wr) |=> tx_buffer_empty)
        else $error("buffer empty did not rise on take");

    COV_FILL: cover property (@(posedge hclk) disable iff (!hresetn)
        take_fill);
    COV_BUF: cover property (@(posedge hclk) disable iff (!hresetn)
        take_buf ##[1:200] take_buf);
    COV_LOAD_AT_TAKE: cover property (@(posedge hclk)
        disable iff (!hresetn) take_buf && data_wr);
    COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(irq));
endmodule : sft_transmitter

// File: testbench/sft_link_partner.sv
// sft_link_partner: far end of the serial line; makes the link clock
// and captures one line bit at each of its rising edges.
// assumes the transmitter settles its line well before the next edge.
`timescale 1ns/1ps
module sft_link_partner
(
    input wire logic run,
    input wire logic tx_serial_out,
    output logic tx_shift_clock
);
    logic bits[$];

    ////////////////////////////////////////////////////////////////////
    // 160 ns period, offset so edges never meet hclk edges
    initial
    begin
        tx_shift_clock = 1'b0;
        #7;
        forever
        begin
            #80;
            tx_shift_clock = run ? ~tx_shift_clock : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // the line still shows the previous bit at the rising edge
    always @(posedge tx_shift_clock)
    begin
        bits.push_back(tx_serial_out);
    end
endmodule : sft_link_partner

// File: testbench/sync_fill_transmitter_tb.sv
// sync_fill_transmitter_tb: register bus master, link partner and
// self-checking sequence for the fill-character transmitter.
// assumes a zero-wait slave; frames re-aligned by a reset per case.
`timescale 1ns/1ps
module sync_fill_transmitter_tb
    import sft_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic tx_shift_clock;
    logic tx_serial_out;
    logic tx_buffer_empty;
    logic fill_char_sent;
    logic irq;
    logic run = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;

    assign hready = hreadyout;

    always #10 hclk = ~hclk;

    sft_transmitter i_sft_transmitter (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tx_shift_clock(tx_shift_clock), .tx_serial_out(tx_serial_out),
        .tx_buffer_empty(tx_buffer_empty),
        .fill_char_sent(fill_char_sent), .irq(irq));

    sft_link_partner i_sft_link_partner (.run(run),
        .tx_serial_out(tx_serial_out), .tx_shift_clock(tx_shift_clock));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1)
        begin
            error_cnt++;
            close_out();
        end
    endtask : wait_rdy

    // one single word transfer; returns at the edge ending the data phase
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= SFT_HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        ahb(1'b1, a, d, rd);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        chk(nm, exp, rd);
    endtask : rdc

    // link edges are counted by captured bits; flags settle 3-4 hclk on
    task automatic wait_bits(input int k);
        wait (i_sft_link_partner.bits.size() >= k);
        repeat (6) @(posedge hclk);
    endtask : wait_bits

    ////////////////////////////////////////////////////////////////////
    // expected line bits of one character, lsb first, parity last
    function automatic logic [31:0] frame_of(input logic [7:0] ch,
                                             input logic [3:0] ctrl);
        logic [7:0] m;
        logic p;
        m = 8'hFF >> (3 - ctrl[1:0]);
        p = ^(ch & m);
        if (!ctrl[2])
            p = ~p;
        frame_of = {24'h0, ch & m};
        if (!ctrl[3])
            frame_of[5 + ctrl[1:0]] = p;
    endfunction : frame_of

    task automatic run_case(input int code);
        logic [7:0] ch[3];
        logic [3:0] ctrl;
        logic [1:0] en;
        logic [31:0] got;
        int n;
        ctrl = {code % 3 == 2, code % 3 == 1, 2'(code)};
        n = code + 5 + (ctrl[3] ? 0 : 1);
        ch[0] = 8'($urandom);
        ch[1] = 8'($urandom);
        ch[2] = 8'($urandom);
        en = 2'($urandom);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        i_sft_link_partner.bits.delete();
        wr(SFT_OFS_CTRL, {28'h0, ctrl});
        wr(SFT_OFS_FILL, {24'h0, ch[2]});
        wr(SFT_OFS_IRQ_EN, {30'h0, en});
        wr(SFT_OFS_DATA, {24'h0, ch[0]});
        @(posedge hclk);
        chk("buf_empty_load", 32'h0, {31'h0, tx_buffer_empty});
        run <= 1'b1;
        wait_bits(2);
        chk("buf_empty_take", 32'h1, {31'h0, tx_buffer_empty});
        chk("fill_sent_data", 32'h0, {31'h0, fill_char_sent});
        wr(SFT_OFS_DATA, {24'h0, ch[1]});
        @(posedge hclk);
        chk("buf_empty_full", 32'h0, {31'h0, tx_buffer_empty});
        wait_bits(3 * n + 2);
        chk("fill_sent_fill", 32'h1, {31'h0, fill_char_sent});
        chk("buf_empty_idle", 32'h1, {31'h0, tx_buffer_empty});
        rdc("state", SFT_OFS_STATE, 32'h3);
        // a load during a fill frame must end the fill run
        wr(SFT_OFS_DATA, {24'h0, ch[0]});
        wait_bits(4 * n + 2);
        run <= 1'b0;
        chk("fill_sent_clr", 32'h0, {31'h0, fill_char_sent});
        for (int f = 0; f < 3; f++)
        begin
            got = 32'h0;
            for (int b = 0; b < n; b++)
                got[b] = i_sft_link_partner.bits[1 + f * n + b];
            chk("frame", frame_of(ch[f], ctrl), got);
        end
        rdc("irq_stat", SFT_OFS_IRQ_STAT, 32'h3);
        chk("irq_on", {31'h0, |en}, {31'h0, irq});
        wr(SFT_OFS_IRQ_CLR, 32'h3);
        repeat (2) @(posedge hclk);
        rdc("irq_stat_clr", SFT_OFS_IRQ_STAT, 32'h0);
        chk("irq_off", 32'h0, {31'h0, irq});
    endtask : run_case

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(47));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("ctrl_rst", SFT_OFS_CTRL, {28'h0, SFT_CTRL_RST});
        rdc("fill_rst", SFT_OFS_FILL, {24'h0, SFT_FILL_RST});
        rdc("data_rst", SFT_OFS_DATA, {24'h0, SFT_DATA_RST});
        rdc("irq_en_rst", SFT_OFS_IRQ_EN, {30'h0, SFT_IRQ_EN_RST});
        rdc("state_rst", SFT_OFS_STATE, 32'h1);
        wr(8'h1C, 32'hFFFFFFFF);
        rdc("unmapped", 8'h1C, 32'h0);
        for (int i = 0; i < 4; i++)
            run_case(i);
        close_out();
    end

    // whole run is some 1100 hclk cycles; a hang is cut well beyond it
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule : sync_fill_transmitter_tb
